// [hdl/crs_params.svh]
// Offsets, field positions, reset values and cycle counts of the sequencer
`ifndef CRS_PARAMS_SVH
`define CRS_PARAMS_SVH

// Register byte offsets on the Avalon-MM slave
`define CRS_OFS_CTRL 4'h0
`define CRS_OFS_STATUS 4'h4
`define CRS_OFS_FIRST_WORD 4'h8

// Control register fields
`define CRS_CTRL_DBR_BIT 0
`define CRS_CTRL_RST 1'b0

// Status register fields
`define CRS_STAT_MODE_LSB 0
`define CRS_STAT_CORE_REL_BIT 3
`define CRS_STAT_FETCHED_BIT 4
`define CRS_STAT_WIDTH_LSB 5
`define CRS_STAT_BIG_BIT 7

// Mode input positions and reset level (weak pull-ups)
`define CRS_MODE_BIG_BIT 0
`define CRS_MODE_W8_BIT 1
`define CRS_MODE_W16_BIT 2
`define CRS_MODE_RST 3'h7

// Reset vector, physical address
`define CRS_RESET_VECTOR 32'h1fc0_0000

// Refill sizes in words
`define CRS_IREFILL_WORDS 3'h4
`define CRS_DREFILL_BLOCK 3'h4
`define CRS_DREFILL_SINGLE 3'h1

// Sequence lengths in system clock cycles
`define CRS_SYNC_SYSTEM_CLOCK_OUTPUT 2
`define CRS_PROP_SYSTEM_CLOCK_OUTPUT 1
`define CRS_FETCH_SYSTEM_CLOCK_OUTPUT 6

// Counter end points of those, in input clock cycles (system clock is input clock / 2)
`define CRS_SYNC_END (2 * `CRS_SYNC_SYSTEM_CLOCK_OUTPUT)
`define CRS_PROP_AT (2 * (`CRS_FETCH_SYSTEM_CLOCK_OUTPUT - `CRS_PROP_SYSTEM_CLOCK_OUTPUT))
`define CRS_FETCH_AT (2 * `CRS_FETCH_SYSTEM_CLOCK_OUTPUT - 1)

`endif

// [hdl/crs_pkg.sv]
// Types shared by the reset sequencer files
package crs_pkg;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_SYNC,
        ST_FLUSH,
        ST_PROP,
        ST_READ,
        ST_RUN
    } crs_state_e;

    typedef enum logic [1:0] {
        BW_32,
        BW_8,
        BW_16,
        BW_64
    } crs_boot_width_e;

endpackage

// [hdl/crs_pin_sync.sv]
// Three-stage synchroniser for asynchronous level inputs
`timescale 1ns/100ps

module crs_pin_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RST = '1
) (
    input wire logic i_mclk,              // Input clock
    input wire logic i_rstn,              // Async reset, active low
    input wire logic [WIDTH-1:0] i_d,     // Asynchronous level
    output logic [WIDTH-1:0] o_q          // Settled level
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } crs_pin_s;

    crs_pin_s r;
    crs_pin_s next_r;

    always_comb begin
        next_r = r;
        next_r.s1 = i_d;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        // Only bits on which stages two and three agree move
        for (int i = 0; i < WIDTH; i++) begin
            if (r.s2[i] == r.s3[i]) begin
                next_r.q[i] = r.s3[i];
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            r <= {RST, RST, RST, RST};
        end else begin
            r <= next_r;
        end
    end

    assign o_q = r.q;

endmodule

// [hdl/crs_rst_sync.sv]
// Reset synchroniser: asserts at once, releases on the input clock
`timescale 1ns/100ps

module crs_rst_sync (
    input wire logic i_mclk,              // Input clock
    input wire logic i_arst_n,            // System reset pin, active low
    output logic o_release                // Reset seen released
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } crs_rst_s;

    crs_rst_s r;
    crs_rst_s next_r;

    always_comb begin
        next_r.s1 = 1'b1;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
    end

    // Release may come at any time; assertion needs no clock
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // A release too close to an edge simply lands one clock later
    assign o_release = r.s2 & r.s3; // RULE_10

endmodule

// [hdl/crs_sequencer.sv]
// Reset sequencer, mode latch and register slave of the processor
`timescale 1ns/100ps
`include "crs_params.svh"

// Operation
// RULE_01: During reset the system clock output runs at half the input clock.
// RULE_02: During reset data bus floats, address latch and strobes stay high.
// RULE_03: During reset the address bus and diagnostic outputs are driven.
// RULE_04: Reset release is detected on a falling system clock edge.
// RULE_05: Instruction read begins six system clocks after detected release.
// RULE_06: Reset is synchronised, adding two cycles before core release.
// RULE_07: One extra cycle carries the fetch request from core to bus.
// RULE_08: Execution starts at the uncached, unmapped vector 0x1FC0_0000.
// RULE_09: Mode inputs are latched transparently while reset is asserted.
// RULE_10: Late release delays recognition one clock, not mode sampling.
// RULE_11: The system clock output keeps running throughout reset.
// RULE_12: Instruction refills are four words; data refills one or four.
// RULE_13: Reverse endian, streaming and partial stores are always enabled.
// RULE_14: Boot code sets usable and cache bits before any data reference.
// RULE_15: Boot code sizes and invalidates the caches before cached code.
// RULE_16: With pull-up mode inputs, warm reset must be held much longer.
// RULE_17: Boot width inputs: 11 32-bit, 10 8-bit, 01 16-bit, 00 64-bit.
// RULE_18: Byte order input high means big endian, low little endian.
// RULE_19: Latched modes stay constant until reset is asserted again.
module crs_sequencer (
    input wire logic i_mclk,                      // Input clock, 10 MHz
    input wire logic i_rstn,                      // Power-on reset, low
    input wire logic i_system_reset_n,            // System reset pin, low
    input wire logic [2:0] i_sync_interrupt_mode_inputs, // Mode pins
    input wire logic i_read_done,                 // Boot read completed
    input wire logic [31:0] i_system_data_bus,    // Data bus, input side
    output logic [31:0] o_system_data_bus,        // Data bus, output side
    output logic o_system_data_bus_oe,            // Data bus drive enable
    output logic o_system_clock_output,           // Input clock / 2
    output logic o_address_latch_enable,          // Address latch, high idle
    output logic o_rd_n,                          // Read strobe, low
    output logic o_wr_n,                          // Write strobe, low
    output logic [31:0] o_system_address_bus,     // Address bus
    output logic [1:0] o_diagnostic_outputs,      // Diagnostic pins
    output logic o_core_reset_n,                  // Core reset, low
    output logic o_fetch_start,                   // First fetch pulse
    output logic o_byte_order_select,             // 1 big, 0 little endian
    output crs_pkg::crs_boot_width_e o_boot_width, // Boot port width
    output logic [2:0] o_instr_refill_size,       // Words per I refill
    output logic [2:0] o_data_refill_size,        // Words per D refill
    output logic o_rev_endian_en,                 // Reverse endian capable
    output logic o_instr_stream_en,               // Instruction streaming
    output logic o_partial_store_en,              // Partial word stores
    input wire logic [3:0] i_avs_address,         // Avalon byte address
    input wire logic i_avs_read,                  // Avalon read
    input wire logic i_avs_write,                 // Avalon write
    input wire logic [3:0] i_avs_byteenable,      // Avalon byte enables
    input wire logic [31:0] i_avs_writedata,      // Avalon write data
    output logic [31:0] o_avs_readdata,           // Avalon read data
    output logic o_avs_waitrequest                // Avalon wait request
);

    typedef struct packed {
        crs_pkg::crs_state_e st;
        logic [3:0] cnt;
        logic system_clock_output;
        logic core_rel;
        logic [2:0] modes;
        logic dbr;
        logic fetched;
        logic [31:0] first_word;
        logic ack;
        logic [31:0] rdata;
    } crs_seq_s;

    crs_seq_s r;
    crs_seq_s next_r;
    logic rst_rel;
    logic [2:0] mode_q;
    logic bus_req;
    logic reading;
    crs_pkg::crs_boot_width_e width;

    crs_rst_sync u_rst_sync (
        .i_mclk(i_mclk),
        .i_arst_n(i_system_reset_n),
        .o_release(rst_rel)
    );

    crs_pin_sync #(
        .WIDTH(3),
        .RST(`CRS_MODE_RST)
    ) u_mode_sync (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_d(i_sync_interrupt_mode_inputs),
        .o_q(mode_q)
    );

    // Boot pins are active low; the code points are the inverted pin pair
    always_comb begin
        case (r.modes[`CRS_MODE_W16_BIT:`CRS_MODE_W8_BIT])
            2'h3: width = crs_pkg::BW_32; // RULE_17
            2'h2: width = crs_pkg::BW_8; // RULE_17
            2'h1: width = crs_pkg::BW_16; // RULE_17
            default: width = crs_pkg::BW_64; // RULE_17
        endcase
    end

    assign bus_req = i_avs_read | i_avs_write;

    always_comb begin
        next_r = r;
        // Free-running divider, untouched by the system reset pin
        next_r.system_clock_output = ~r.system_clock_output; // RULE_01 RULE_11
        // Latch is open while reset is seen, closes on its release
        if (!rst_rel) begin
            next_r.modes = mode_q; // RULE_09 RULE_10 RULE_19
        end
        case (r.st)
            crs_pkg::ST_RESET: begin
                next_r.cnt = 4'h0;
                next_r.core_rel = 1'b0;
                // Falls on this edge when the divider is high
                if (rst_rel && r.system_clock_output) begin
                    next_r.st = crs_pkg::ST_SYNC; // RULE_04
                end
            end
            crs_pkg::ST_SYNC: begin
                next_r.cnt = r.cnt + 4'h1;
                if (next_r.cnt == 4'(`CRS_SYNC_END)) begin
                    next_r.st = crs_pkg::ST_FLUSH;
                    next_r.core_rel = 1'b1; // RULE_06
                end
            end
            crs_pkg::ST_FLUSH: begin
                next_r.cnt = r.cnt + 4'h1;
                if (next_r.cnt == 4'(`CRS_PROP_AT)) begin
                    next_r.st = crs_pkg::ST_PROP; // RULE_07
                end
            end
            crs_pkg::ST_PROP: begin
                next_r.cnt = r.cnt + 4'h1;
                if (next_r.cnt == 4'(`CRS_FETCH_AT)) begin
                    next_r.st = crs_pkg::ST_READ; // RULE_05
                end
            end
            crs_pkg::ST_READ: begin
                if (i_read_done) begin
                    next_r.st = crs_pkg::ST_RUN;
                    next_r.fetched = 1'b1;
                    next_r.first_word = i_system_data_bus;
                end
            end
            crs_pkg::ST_RUN: begin
                next_r.st = crs_pkg::ST_RUN;
            end
            default: begin
                next_r.st = crs_pkg::ST_RESET;
            end
        endcase
        // A new assertion restarts the whole sequence
        if (!rst_rel) begin
            next_r.st = crs_pkg::ST_RESET;
            next_r.core_rel = 1'b0;
            next_r.fetched = 1'b0;
        end

        // Avalon slave: one wait state, then the answer
        next_r.ack = bus_req & ~r.ack;
        if (i_avs_read && !r.ack) begin
            case (i_avs_address)
                `CRS_OFS_CTRL: begin
                    next_r.rdata = 32'h0;
                    next_r.rdata[`CRS_CTRL_DBR_BIT] = r.dbr;
                end
                `CRS_OFS_STATUS: begin
                    next_r.rdata = 32'h0;
                    next_r.rdata[`CRS_STAT_MODE_LSB +: 3] = r.modes;
                    next_r.rdata[`CRS_STAT_CORE_REL_BIT] = r.core_rel;
                    next_r.rdata[`CRS_STAT_FETCHED_BIT] = r.fetched;
                    next_r.rdata[`CRS_STAT_WIDTH_LSB +: 2] = width;
                    next_r.rdata[`CRS_STAT_BIG_BIT] =
                        r.modes[`CRS_MODE_BIG_BIT];
                end
                `CRS_OFS_FIRST_WORD: begin
                    next_r.rdata = r.first_word;
                end
                default: begin
                    next_r.rdata = 32'h0;
                end
            endcase
        end
        if (i_avs_write && r.ack && i_avs_address == `CRS_OFS_CTRL
                && i_avs_byteenable[0]) begin
            next_r.dbr = i_avs_writedata[`CRS_CTRL_DBR_BIT];
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            r.st <= crs_pkg::ST_RESET;
            r.cnt <= 4'h0;
            r.system_clock_output <= 1'b0;
            r.core_rel <= 1'b0;
            r.modes <= `CRS_MODE_RST;
            r.dbr <= `CRS_CTRL_RST;
            r.fetched <= 1'b0;
            r.first_word <= 32'h0;
            r.ack <= 1'b0;
            r.rdata <= 32'h0;
        end else begin
            r <= next_r;
        end
    end

    // Outputs
    assign o_system_clock_output = r.system_clock_output; // RULE_01
    assign o_system_data_bus = 32'h0;
    // Never drives the data bus; the boot read only samples it
    assign o_system_data_bus_oe = 1'b0; // RULE_02
    // A new reset drops the strobes at once, not at the next edge
    assign reading = (r.st == crs_pkg::ST_READ) && rst_rel;
    assign o_address_latch_enable = !reading; // RULE_02
    assign o_rd_n = !reading; // RULE_02
    assign o_wr_n = 1'b1; // RULE_02
    // Vector is driven outside the read too, so the bus never floats
    assign o_system_address_bus = `CRS_RESET_VECTOR; // RULE_03 RULE_08
    assign o_diagnostic_outputs = {r.fetched, r.core_rel}; // RULE_03
    // Gated by the release so a new reset reaches the core at once
    assign o_core_reset_n = r.core_rel & rst_rel; // RULE_06
    assign o_fetch_start = (r.st == crs_pkg::ST_PROP) &&
                           (r.cnt == 4'(`CRS_FETCH_AT - 1));
    assign o_byte_order_select = r.modes[`CRS_MODE_BIG_BIT]; // RULE_18
    assign o_boot_width = width;
    assign o_instr_refill_size = `CRS_IREFILL_WORDS; // RULE_12
    assign o_data_refill_size = r.dbr ? `CRS_DREFILL_BLOCK
                                      : `CRS_DREFILL_SINGLE; // RULE_12
    assign o_rev_endian_en = 1'b1; // RULE_13
    assign o_instr_stream_en = 1'b1; // RULE_13
    assign o_partial_store_en = 1'b1; // RULE_13
    assign o_avs_readdata = r.rdata;
    assign o_avs_waitrequest = bus_req & ~r.ack;

    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    sequence s_detect;
        r.st == crs_pkg::ST_RESET ##1 r.st == crs_pkg::ST_SYNC;
    endsequence

    sequence s_flush_to_read;
        r.st == crs_pkg::ST_PROP ##1 r.st == crs_pkg::ST_READ;
    endsequence

    chk_system_clock_output_half_rate: assert property ( // RULE_01
        $past(i_rstn) |->
            o_system_clock_output != $past(o_system_clock_output))
        else $error("system clock output did not toggle");

    chk_reset_bus_idle: assert property ( // RULE_02
        !o_core_reset_n |-> !o_system_data_bus_oe && o_address_latch_enable
            && o_rd_n && o_wr_n)
        else $error("bus not idle during reset");

    chk_reset_addr_drive: assert property ( // RULE_03
        (r.st == crs_pkg::ST_RESET) |->
            o_system_address_bus == `CRS_RESET_VECTOR)
        else $error("address bus not driven during reset");

    chk_detect_on_fall: assert property ( // RULE_04
        s_detect |-> !o_system_clock_output && $past(o_system_clock_output))
        else $error("release not detected on falling edge");

    chk_core_release: assert property ( // RULE_06
        disable iff (!i_rstn || !rst_rel)
        s_detect |-> !o_core_reset_n [*4] ##1 o_core_reset_n)
        else $error("core released at wrong cycle");

    chk_fetch_delay: assert property ( // RULE_05
        disable iff (!i_rstn || !rst_rel)
        s_detect |-> ##11 (r.st == crs_pkg::ST_READ) && !o_rd_n
            && o_system_clock_output)
        else $error("boot read not six system clocks after release");

    chk_prop_cycle: assert property ( // RULE_07
        disable iff (!i_rstn || !rst_rel)
        (r.st == crs_pkg::ST_FLUSH) ##1 (r.st == crs_pkg::ST_PROP)
            |-> s_flush_to_read)
        else $error("fetch request took wrong path");

    chk_vector_addr: assert property ( // RULE_08
        !o_address_latch_enable |->
            o_system_address_bus == `CRS_RESET_VECTOR)
        else $error("boot read not at reset vector");

    chk_mode_hold: assert property ( // RULE_19
        (rst_rel && $past(rst_rel)) |-> $stable(r.modes))
        else $error("latched modes changed outside reset");

    chk_mode_follow: assert property ( // RULE_09
        (!rst_rel) |=> r.modes == $past(mode_q))
        else $error("mode latch not transparent in reset");

    chk_refill_size: assert property ( // RULE_12
        o_instr_refill_size == 3'h4 &&
            o_data_refill_size == (r.dbr ? 3'h4 : 3'h1))
        else $error("refill size wrong");

    chk_fixed_caps: assert property ( // RULE_13
        o_rev_endian_en && o_instr_stream_en && o_partial_store_en)
        else $error("fixed capability disabled");

endmodule

// [verification/crs_boot_mem.sv]
// Boot memory model answering the first instruction read
`timescale 1ns/100ps

module crs_boot_mem (
    input wire logic i_mclk,          // Input clock
    input wire logic i_ale_n,         // Address latch enable, low in read
    input wire logic i_rd_n,          // Read strobe, low
    input wire logic [3:0] i_wait,    // Wait cycles before the answer
    input wire logic [31:0] i_word,   // Word stored at the vector
    output logic o_read_done,         // One-cycle read answer
    output logic [31:0] o_data        // Data bus toward the device
);
    int cnt = 0;
    logic [31:0] last = 32'h0;

    initial o_read_done = 1'b0;
    initial o_data = 32'h0;

    // Image is opaque; status, cache sizing and invalidation
    // are the boot code's duty
    always @(posedge i_mclk) begin
        if (!i_ale_n && !i_rd_n && !o_read_done && cnt >= i_wait) begin
            o_read_done <= 1'b1;
            o_data <= i_word;
            last <= i_word;
            cnt <= 0;
        end else begin
            // Released bus shows the inverse, never a stale match
            o_read_done <= 1'b0;
            o_data <= ~last;
            cnt <= (!i_ale_n && !i_rd_n) ? cnt + 1 : 0;
        end
    end
endmodule

// [verification/testbench.sv]
// Self-checking bench for the reset sequencer and mode latch
`timescale 1ns/100ps

module testbench;
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic pin_n = 1'b0;
    logic [2:0] mode = 3'h7;
    logic done;
    logic [31:0] din, dout, addr, rdata;
    logic oe, sclk, ale_n, rd_n, wr_n, core_n, fetch, big, oe_en, st_en, ps_en;
    logic [1:0] diag;
    crs_pkg::crs_boot_width_e bw;
    logic [2:0] irs, drs;
    logic [3:0] av_a = 4'h0, av_be = 4'h0, wait_c = 4'h0;
    logic av_rd = 1'b0, av_wr = 1'b0, wreq;
    logic [31:0] av_d = 32'h0, word = 32'h0, q;
    int failures = 0, comparisons = 0;
    int words[$];

    crs_sequencer dut (.i_mclk(i_mclk), .i_rstn(i_rstn),
        .i_system_reset_n(pin_n), .i_sync_interrupt_mode_inputs(mode),
        .i_read_done(done), .i_system_data_bus(din),
        .o_system_data_bus(dout), .o_system_data_bus_oe(oe),
        .o_system_clock_output(sclk), .o_address_latch_enable(ale_n),
        .o_rd_n(rd_n), .o_wr_n(wr_n), .o_system_address_bus(addr),
        .o_diagnostic_outputs(diag), .o_core_reset_n(core_n),
        .o_fetch_start(fetch), .o_byte_order_select(big),
        .o_boot_width(bw), .o_instr_refill_size(irs),
        .o_data_refill_size(drs), .o_rev_endian_en(oe_en),
        .o_instr_stream_en(st_en), .o_partial_store_en(ps_en),
        .i_avs_address(av_a), .i_avs_read(av_rd), .i_avs_write(av_wr),
        .i_avs_byteenable(av_be), .i_avs_writedata(av_d),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq));

    crs_boot_mem mem (.i_mclk(i_mclk), .i_ale_n(ale_n), .i_rd_n(rd_n),
        .i_wait(wait_c), .i_word(word), .o_read_done(done), .o_data(din));

    initial begin
        forever #50 i_mclk = ~i_mclk;
    end

    task automatic give_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp,
            input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic timed_out();
        failures++;
        give_verdict();
    endtask

    // One Avalon access; held until waitrequest is seen low at an edge
    task automatic av(input logic wr, input logic [3:0] a,
            input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge i_mclk);
        av_a <= a;
        av_wr <= wr;
        av_rd <= !wr;
        av_be <= be;
        av_d <= d;
        do begin
            @(posedge i_mclk);
            n++;
            if (n > 50) timed_out();
        end while (wreq !== 1'b0);
        q = rdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
    endtask

    task automatic statics();
        chk("data_oe", 32'h0, {31'h0, oe});
        chk("data_out", 32'h0, dout);
        chk("wr_n", 32'h1, {31'h0, wr_n});
        chk("address", 32'h1fc0_0000, addr);
        chk("irefill", 32'h4, {29'h0, irs});
        chk("always_en", 32'h7, {29'h0, oe_en, st_en, ps_en});
    endtask

    task automatic boot(input int m, input bit abort);
        int n, cr, al, fe, w, st;
        logic s;
        @(posedge i_mclk);
        pin_n <= 1'b0;
        mode <= m[2:0];
        wait_c <= 4'($urandom_range(0, 5));
        word <= $urandom;
        #1;
        chk("core_reset_n", 32'h0, {31'h0, core_n});
        // Long hold lets weak pull-up mode levels settle
        repeat (20) @(posedge i_mclk);
        #1;
        s = sclk;
        @(posedge i_mclk);
        #1;
        chk("system_clock_output_toggle", {31'h0, ~s}, {31'h0, sclk});
        chk("ale_n", 32'h1, {31'h0, ale_n});
        chk("rd_n", 32'h1, {31'h0, rd_n});
        statics();
        words.push_back(word);
        repeat ($urandom_range(0, 1)) @(posedge i_mclk);
        if (abort) begin
            pin_n <= 1'b1;
            repeat (6) @(posedge i_mclk);
            pin_n <= 1'b0;
            #1;
            chk("abort_core", 32'h0, {31'h0, core_n});
            repeat (10) @(posedge i_mclk);
        end
        pin_n <= 1'b1;
        n = 0;
        cr = 0;
        fe = 0;
        do begin
            @(posedge i_mclk);
            #1;
            n++;
            if (core_n === 1'b1 && cr == 0) cr = n;
            if (fetch === 1'b1) fe++;
            if (n > 40) timed_out();
        end while (ale_n !== 1'b0);
        al = n;
        chk("fetch_after_core", 32'd7, al - cr);
        chk("fetch_at", 32'h1, {31'h0, al inside {15, 16}});
        chk("system_clock_output_at_fetch", 32'h1, {31'h0, sclk});
        chk("fetch_pulses", 32'h1, fe);
        chk("rd_n_read", 32'h0, {31'h0, rd_n});
        mode <= ~m[2:0];
        n = 0;
        do begin
            @(posedge i_mclk);
            #1;
            n++;
            if (n > 30) timed_out();
        end while (ale_n !== 1'b1);
        chk("rd_n_done", 32'h1, {31'h0, rd_n});
        chk("diag", 32'h3, {30'h0, diag});
        w = 3 - (m >> 1);
        repeat (8) @(posedge i_mclk);
        chk("byte_order", m & 1, {31'h0, big});
        chk("boot_width", w, {30'h0, bw});
        st = ((m & 1) << 7) | (w << 5) | 32'h18 | m;
        av(1'b0, 4'h4, 32'h0, 4'hf);
        chk("status", st, q);
        av(1'b0, 4'h8, 32'h0, 4'hf);
        chk("first_word", words.pop_front(), q);
        statics();
    endtask

    initial begin
        void'($urandom(71855));
        repeat (10) @(posedge i_mclk);
        i_rstn <= 1'b1;
        @(posedge i_mclk);
        #1;
        chk("drefill_rst", 32'h1, {29'h0, drs});
        // Write without the low byte lane is dropped
        av(1'b1, 4'h0, 32'h1, 4'he);
        chk("drefill_be", 32'h1, {29'h0, drs});
        av(1'b1, 4'h0, $urandom | 32'h1, 4'hf);
        #1;
        chk("drefill_block", 32'h4, {29'h0, drs});
        av(1'b0, 4'h0, 32'h0, 4'hf);
        chk("ctrl_bit", 32'h1, {31'h0, q[0]});
        av(1'b1, 4'hc, $urandom, 4'hf);
        av(1'b0, 4'hc, 32'h0, 4'hf);
        chk("unmapped", 32'h0, q);
        av(1'b1, 4'h0, 32'h0, 4'hf);
        #1;
        chk("drefill_single", 32'h1, {29'h0, drs});
        for (int m = 0; m < 8; m++) begin
            boot(m, m == 0);
        end
        give_verdict();
    end
endmodule
